// file: adc_cfg.svh
// Timing counts, widths and reset values for the converter control block
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

// Clock rate in MHz
`define ADC_CLK_MHZ        250
// Power-up pulse length in ns, and its count in cycles, rounded down
`define ADC_POWERUP_NS     1500
`define ADC_POWERUP_CYCLES ((`ADC_POWERUP_NS * `ADC_CLK_MHZ) / 1000)
// Conversion time in ns, and its count in cycles, rounded down
`define ADC_CONV_NS        2300
`define ADC_CONV_CYCLES    ((`ADC_CONV_NS * `ADC_CLK_MHZ) / 1000)
// Result and bus widths
`define ADC_RESULT_BITS    10
`define ADC_BYTE_BITS      8
`define ADC_LSB_BITS       2
// Cycles given to each successive approximation decision
`define ADC_BIT_CYCLES     (`ADC_CONV_CYCLES / `ADC_RESULT_BITS)
// Counter widths
`define ADC_CNT_BITS       10
`define ADC_IDX_BITS       4
// Reset values
`define ADC_RESULT_RST     10'h000
`define ADC_TRIAL_RST      10'h000
`define ADC_BYTE_RST       8'h00
// Pin levels assumed during reset: start low, chip select and read high
`define ADC_PIN_RST        3'b110

`endif

// file: adc_pkg.sv
// Types shared by the converter control block, its checker, the far side model and the bench
package adc_pkg;

  // Control sequence of the converter
  typedef enum logic [1:0] {
    st_off     = 2'b00,
    st_ready   = 2'b01,
    st_convert = 2'b10
  } conv_state_type;

  // Host side pins, in the order chip_select_n, read_n, start_conversion_n
  typedef struct packed {
    logic chip_select_n;
    logic read_n;
    logic start_conversion_n;
  } host_pins_type;

  // Three-state data bus, split into value and output enable
  typedef struct packed {
    logic [7:0] data;
    logic       oe;
  } data_bus_type;

endpackage

// file: pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
module pin_sync #(
  parameter int         WIDTH     = 3,
  parameter logic [2:0] RST_LEVEL = 3'b110
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  genvar i;

  ////////////////////////////////////////////////////////////////////////////
  // One chain per pin; only the second and third stages are compared
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      wire  agree = (s2_q == s3_q);
      wire  lvl_d = agree ? s3_q : level[i];

      // Chain and filtered level; first stage feeds only the second
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          s1_q     <= RST_LEVEL[i];
          s2_q     <= RST_LEVEL[i];
          s3_q     <= RST_LEVEL[i];
          level[i] <= RST_LEVEL[i];
          rise[i]  <= 1'b0;
          fall[i]  <= 1'b0;
        end else begin
          s1_q     <= pin[i];
          s2_q     <= s1_q;
          s3_q     <= s2_q;
          level[i] <= lvl_d;
          rise[i]  <= lvl_d & ~level[i];
          fall[i]  <= ~lvl_d & level[i];
        end
      end
    end
  endgenerate

endmodule // pin_sync

// file: adc_convert_start_and_read_port.sv
// Start, busy, power-down, successive approximation and byte read control
`include "adc_cfg.svh"

module adc_convert_start_and_read_port (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire adc_pkg::host_pins_type host_pins,
  input  wire logic                   comparator_high,
  output adc_pkg::data_bus_type       data_bus_lines,
  output logic                        busy,
  output logic                        power_enable,
  output logic                        auto_powerdown_mode,
  output logic                        sample_hold,
  output logic [9:0]                  trial_code
);

  ////////////////////////////////////////////////////////////////////////////
  // Constants sized to the counters they meet
  localparam logic [9:0] POWERUP_CYCLES = 10'(`ADC_POWERUP_CYCLES);
  localparam logic [9:0] BIT_CYCLES     = 10'(`ADC_BIT_CYCLES);
  localparam logic [3:0] TOP_BIT        = 4'(`ADC_RESULT_BITS - 1);
  localparam int         PIN_CS         = 2;
  localparam int         PIN_RD         = 1;
  localparam int         PIN_START      = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  // All three host pins are asynchronous to clk
  pin_sync #(
    .WIDTH     (3),
    .RST_LEVEL (`ADC_PIN_RST)
  ) u_pin_sync (
    .clk   (clk),
    .nrst  (nrst),
    .pin   (host_pins),
    .level (pin_level),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  wire start_level = pin_level[PIN_START];
  wire start_rise  = pin_rise[PIN_START];
  wire start_fall  = pin_fall[PIN_START];
  wire cs_active   = ~pin_level[PIN_CS];
  wire rd_active   = ~pin_level[PIN_RD];

  ////////////////////////////////////////////////////////////////////////////
  // State and storage
  adc_pkg::conv_state_type state_q;
  adc_pkg::conv_state_type state_d;
  logic [9:0]              pulse_cnt_q;
  logic [9:0]              pulse_cnt_d;
  logic                    pulse_q;
  logic                    pulse_d;
  logic [9:0]              step_cnt_q;
  logic [9:0]              step_cnt_d;
  logic [3:0]              bit_idx_q;
  logic [3:0]              bit_idx_d;
  logic [9:0]              sar_q;
  logic [9:0]              sar_d;
  logic [9:0]              result_q;
  logic [9:0]              result_d;
  logic                    lsb_next_q;
  logic                    lsb_next_d;
  logic                    read_q;
  logic                    auto_pd_q;
  logic                    auto_pd_d;
  logic                    power_q;
  logic                    power_d;

  ////////////////////////////////////////////////////////////////////////////
  // Power-up pulse, retriggered by every rising start edge
  wire pulse_last = pulse_q && (pulse_cnt_q == POWERUP_CYCLES - 10'h001);

  always_comb begin
    pulse_d     = pulse_q;
    pulse_cnt_d = pulse_cnt_q;
    if (start_rise) begin
      pulse_d     = 1'b1;
      pulse_cnt_d = 10'h000;
    end else if (pulse_last) begin
      pulse_d     = 1'b0;
      pulse_cnt_d = 10'h000;
    end else if (pulse_q) begin
      pulse_cnt_d = pulse_cnt_q + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion decode
  // Falling edge is honoured only once the pulse has gone low
  wire start_ok   = start_fall && !pulse_q && power_q
                    && (state_q == adc_pkg::st_ready);
  wire step_done  = (state_q == adc_pkg::st_convert)
                    && (step_cnt_q == BIT_CYCLES - 10'h001);
  wire last_bit   = (bit_idx_q == 4'h0);
  wire conv_end   = step_done && last_bit;

  // Trial code: bits decided so far plus the bit under test
  wire [9:0] test_bit  = 10'h001 << bit_idx_q;
  wire [9:0] trial_now = sar_q | test_bit;
  // Straight binary: keep the bit if input is at or above the trial level
  wire [9:0] sar_keep  = comparator_high ? trial_now : sar_q;
  // Next trial follows the next bit index, so it stands for a whole bit time
  wire [9:0] trial_d   = (state_d == adc_pkg::st_convert)
                         ? (sar_d | (10'h001 << bit_idx_d))
                         : `ADC_TRIAL_RST;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequence and power control
  always_comb begin
    state_d    = state_q;
    step_cnt_d = step_cnt_q;
    bit_idx_d  = bit_idx_q;
    sar_d      = sar_q;
    result_d   = result_q;
    auto_pd_d  = auto_pd_q;
    power_d    = power_q;
    case (state_q)
      adc_pkg::st_off: begin
        // Asleep until the pulse has let the analog core settle
        if (pulse_last) begin
          power_d = 1'b1;
          state_d = adc_pkg::st_ready;
        end
      end
      adc_pkg::st_ready: begin
        if (start_ok) begin
          state_d    = adc_pkg::st_convert;
          step_cnt_d = 10'h000;
          bit_idx_d  = TOP_BIT;
          sar_d      = `ADC_RESULT_RST;
        end
      end
      adc_pkg::st_convert: begin
        if (step_done) begin
          sar_d      = sar_keep;
          step_cnt_d = 10'h000;
          bit_idx_d  = bit_idx_q - 4'h1;
        end else begin
          step_cnt_d = step_cnt_q + 10'h001;
        end
        if (conv_end) begin
          result_d  = sar_keep;
          auto_pd_d = ~start_level;
          if (!start_level) begin
            // Low start pin at the end means sleep until next pulse
            power_d = 1'b0;
            state_d = adc_pkg::st_off;
          end else begin
            state_d = adc_pkg::st_ready;
          end
        end
      end
      default: begin
        state_d = adc_pkg::st_off;
        power_d = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port decode
  // Output enable needs chip select and read together
  wire       read_d    = cs_active && rd_active;
  wire       read_done = read_q && !read_d;
  wire [7:0] msb_byte  = result_q[9:2];
  wire [7:0] lsb_byte  = {6'h00, result_q[1:0]};
  wire [7:0] byte_sel  = lsb_next_q ? lsb_byte : msb_byte;
  // A fresh result always restarts at the MSB byte, even mid-read
  wire       lsb_flip  = read_done ? ~lsb_next_q : lsb_next_q;
  wire       busy_d    = (state_d == adc_pkg::st_convert);

  always_comb begin
    lsb_next_d = lsb_flip;
    if (conv_end) begin
      lsb_next_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulse_q     <= 1'b0;
      pulse_cnt_q <= 10'h000;
    end else begin
      pulse_q     <= pulse_d;
      pulse_cnt_q <= pulse_cnt_d;
    end
  end

  // Conversion registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q    <= adc_pkg::st_off;
      step_cnt_q <= 10'h000;
      bit_idx_q  <= 4'h0;
      sar_q      <= `ADC_RESULT_RST;
      result_q   <= `ADC_RESULT_RST;
      auto_pd_q  <= 1'b0;
      power_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      step_cnt_q <= step_cnt_d;
      bit_idx_q  <= bit_idx_d;
      sar_q      <= sar_d;
      result_q   <= result_d;
      auto_pd_q  <= auto_pd_d;
      power_q    <= power_d;
    end
  end

  // Output registers; bus released at reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      read_q              <= 1'b0;
      lsb_next_q          <= 1'b0;
      data_bus_lines.oe   <= 1'b0;
      data_bus_lines.data <= `ADC_BYTE_RST;
      busy                <= 1'b0;
      sample_hold         <= 1'b0;
      trial_code          <= `ADC_TRIAL_RST;
      power_enable        <= 1'b0;
      auto_powerdown_mode <= 1'b0;
    end else begin
      read_q              <= read_d;
      lsb_next_q          <= lsb_next_d;
      data_bus_lines.oe   <= read_d;
      data_bus_lines.data <= read_d ? byte_sel : `ADC_BYTE_RST;
      busy                <= busy_d;
      sample_hold         <= busy_d;
      trial_code          <= trial_d;
      power_enable        <= power_d;
      auto_powerdown_mode <= auto_pd_d;
    end
  end

endmodule // adc_convert_start_and_read_port

// file: adc_convert_start_and_read_port_assertions.sv
// Port checker for the converter control block
module adc_port_checker (
  input wire logic                   clk,
  input wire logic                   nrst,
  input wire adc_pkg::host_pins_type host_pins,
  input wire adc_pkg::data_bus_type  data_bus_lines,
  input wire logic                   busy,
  input wire logic                   power_enable,
  input wire logic                   auto_powerdown_mode,
  input wire logic                   sample_hold,
  input wire logic [9:0]             trial_code
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] busy_cnt_q;
  // Busy length counter; too long for a repetition
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) busy_cnt_q <= 10'h000;
    else busy_cnt_q <= busy ? busy_cnt_q + 10'h001 : 10'h000;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  busy_len_a: assert property ($fell(busy) |-> busy_cnt_q == 10'h23a)
    else $error("busy length wrong");
  hold_mirror_a: assert property (sample_hold == busy)
    else $error("hold differs from busy");
  start_busy_a: assert property ($rose(busy) |-> $past(!host_pins.start_conversion_n, 3))
    else $error("busy rose without start fall");
  powered_start_a: assert property ($rose(busy) |-> power_enable)
    else $error("conversion while powered down");
  first_trial_a: assert property ($rose(busy) |-> trial_code == 10'h200)
    else $error("first trial not midscale");
  trial_idle_a: assert property (!busy |-> trial_code == 10'h000)
    else $error("trial code outside conversion");
  end_mode_a: assert property ($fell(busy) |-> power_enable != auto_powerdown_mode)
    else $error("power state disagrees with mode");
  bus_release_a: assert property ((host_pins.chip_select_n || host_pins.read_n) [*7]
    |-> !data_bus_lines.oe)
    else $error("bus driven without select and read");
  drive_cause_a: assert property ($rose(data_bus_lines.oe)
    |-> $past(!host_pins.chip_select_n && !host_pins.read_n, 2))
    else $error("bus driven without cause");
  idle_data_a: assert property (!data_bus_lines.oe |-> data_bus_lines.data == 8'h00)
    else $error("data not cleared when released");
  cover property ($fell(busy));
  cover property ($rose(data_bus_lines.oe));
  cover property ($rose(power_enable));
endmodule // adc_port_checker

bind adc_convert_start_and_read_port adc_port_checker adc_port_checker_inst (
  .clk(clk), .nrst(nrst), .host_pins(host_pins), .data_bus_lines(data_bus_lines),
  .busy(busy), .power_enable(power_enable), .auto_powerdown_mode(auto_powerdown_mode),
  .sample_hold(sample_hold), .trial_code(trial_code)
);

// file: host_side.sv
// Far side model: analog comparator and the host's view of the bus
module host_side (
  input  wire logic                  clk,
  input  wire logic [9:0]            analog_level,
  input  wire logic [9:0]            trial_code,
  input  wire adc_pkg::data_bus_type data_bus_lines,
  output logic                       comparator_high,
  output logic [7:0]                 bus_value
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] last_q = 8'h00;
  // Ideal comparator, so the result must equal the level exactly
  assign comparator_high = (analog_level >= trial_code);
  // Released bus shows the inverse of the last byte, so stale data never matches
  assign bus_value = data_bus_lines.oe ? data_bus_lines.data : ~last_q;
  // Remember the last driven byte
  always_ff @(posedge clk) begin
    if (data_bus_lines.oe) last_q <= data_bus_lines.data;
  end
endmodule // host_side

// file: adc_convert_start_and_read_port_test.sv
// Self-checking bench for the converter control block
module adc_convert_start_and_read_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic                   clk   = 1'b0;
  logic                   nrst  = 1'b0;
  adc_pkg::host_pins_type pins  = 3'b110;
  logic [9:0]             level = 10'h000;
  logic                   comp_high;
  adc_pkg::data_bus_type  bus;
  logic                   busy, pwr, apd, hold;
  logic [9:0]             trial;
  logic [7:0]             seen;
  int                     mismatches = 0;
  int                     cmp_count  = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, design and far side
  always #2 clk = ~clk;
  adc_convert_start_and_read_port adc_convert_start_and_read_port_inst (
    .clk(clk), .nrst(nrst), .host_pins(pins), .comparator_high(comp_high),
    .data_bus_lines(bus), .busy(busy), .power_enable(pwr), .auto_powerdown_mode(apd),
    .sample_hold(hold), .trial_code(trial));
  host_side host_side_inst (.clk(clk), .analog_level(level), .trial_code(trial),
    .data_bus_lines(bus), .comparator_high(comp_high), .bus_value(seen));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  // Rising start powers up; a fall inside the pulse is dropped, not deferred
  task automatic power_up;
    pins.start_conversion_n = 1'b1;
    tick(20);
    pins.start_conversion_n = 1'b0;
    tick(300);
    check("power early", pwr, 1'b0);
    tick(100);
    check("power late", pwr, 1'b1);
    check("busy dropped", busy, 1'b0);
    pins.start_conversion_n = 1'b1;
    tick(20);
    // Powered and ready now, so only the running pulse can refuse this fall
    pins.start_conversion_n = 1'b0;
    tick(20);
    check("busy in pulse", busy, 1'b0);
    pins.start_conversion_n = 1'b1;
    tick(400);
  endtask
  // One conversion; stay_low asks for power-down at the end
  task automatic convert(input logic [9:0] lv, input logic stay_low);
    int n;
    level = lv;
    pins.start_conversion_n = 1'b0;
    n = 0;
    while (busy !== 1'b1 && n < 10) begin tick(1); n++; end
    check("busy rise", busy, 1'b1);
    check("hold", hold, 1'b1);
    check("first trial", trial, 10'h200);
    tick(10);
    pins.start_conversion_n = ~stay_low;
    n = 10;
    while (busy === 1'b1 && n < 700) begin tick(1); n++; end
    check("busy length", 10'(n), 10'd570);
    check("power after", pwr, !stay_low);
    check("auto mode", apd, stay_low);
    tick(400);
  endtask
  // Select before read, then release in the reverse order
  task automatic read_byte(input logic [7:0] exp);
    int n;
    pins.chip_select_n = 1'b0;
    tick(1);
    pins.read_n = 1'b0;
    n = 0;
    while (bus.oe !== 1'b1 && n < 10) begin tick(1); n++; end
    check("data", seen, exp);
    pins.read_n = 1'b1;
    tick(1);
    pins.chip_select_n = 1'b1;
    tick(8);
    check("released", bus.oe, 1'b0);
    check("idle data", bus.data, 8'h00);
  endtask
  // Select alone drives nothing; reads give MSBs, LSBs, then MSBs again
  task automatic read_result(input logic [9:0] lv);
    pins.chip_select_n = 1'b0;
    tick(10);
    check("select only", bus.oe, 1'b0);
    pins.chip_select_n = 1'b1;
    tick(10);
    read_byte(lv[9:2]);
    read_byte({6'h00, lv[1:0]});
    read_byte(lv[9:2]);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    repeat (10) @(posedge clk);
    #1;
    nrst = 1'b1;
    tick(2);
    power_up;
    convert(10'h2a5, 1'b0);
    read_result(10'h2a5);
    convert(10'h3ff, 1'b0);
    read_result(10'h3ff);
    convert(10'h000, 1'b1);
    read_result(10'h000);
    power_up;
    convert(10'h155, 1'b0);
    read_result(10'h155);
    stop_test;
  end
  // Whole run needs about 24 us
  initial begin
    #60000;
    mismatches++;
    stop_test;
  end
endmodule // adc_convert_start_and_read_port_test
